// ==== src/css_top.sv ====
// Register bank for revision and calibration set selection, with the calibration path.
// Assumes an APB master on pclk and a converter that presents one result per pulse.
`timescale 1ns/1ns
module css_top
  import css_pkg::*;
#(
  parameter logic [2:0] SILICON_REVISION = 3'h1  // Arbitrary value.
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        raw_valid,
  input  wire css_result_t raw_result,
  input  wire logic        scale_2x,
  output logic             cal_valid,
  output css_result_t      cal_result
);

  logic [23:0]  calibration_set_select;
  css_cal_set_t set_a;
  css_cal_set_t set_b;
  css_cal_set_t chosen;
  logic         apply;

  logic         setup;
  logic         wr_take;
  logic [7:0]   idx;
  logic         addr_ok;
  logic         mapped;
  logic [23:0]  rd_val;

  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h00_0000);

  // Merges write data into a register under the byte strobes.
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [23:0] r;
    r = old;
    for (int b = 0; b < 3; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    rd_val = 24'h00_0000;
    mapped = addr_ok;
    unique case (idx)
      IDX_PART_REVISION: rd_val[REV_LSB +: REV_W] = SILICON_REVISION;
      IDX_CAL_SET_SEL:   rd_val = calibration_set_select & SEL_USED_MASK;
      IDX_OFFSET_CAL_A:  rd_val = set_a.offset;
      IDX_OFFSET_CAL_B:  rd_val = set_b.offset;
      IDX_GAIN_CAL_A:    rd_val = set_a.gain;
      IDX_GAIN_CAL_B:    rd_val = set_b.gain;
      default:           mapped = 1'b0;
    endcase
  end

  // One wait-free access phase: answer is registered at the end of setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= (mapped && !pwrite) ? {8'h00, rd_val} : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Selectors; unused bits 23:16 and 11:10 never store.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calibration_set_select <= SEL_RESET;
    end else if (wr_take && idx == IDX_CAL_SET_SEL) begin
      calibration_set_select <= merge(calibration_set_select, pwdata, pstrb) & SEL_USED_MASK;
    end
  end

  // Two independent calibration sets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_a.offset <= OFFSET_RESET;
      set_a.gain   <= GAIN_RESET;
      set_b.offset <= OFFSET_RESET;
      set_b.gain   <= GAIN_RESET;
    end else if (wr_take) begin
      unique case (idx)
        IDX_OFFSET_CAL_A: set_a.offset <= merge(set_a.offset, pwdata, pstrb);
        IDX_OFFSET_CAL_B: set_b.offset <= merge(set_b.offset, pwdata, pstrb);
        IDX_GAIN_CAL_A:   set_a.gain   <= merge(set_a.gain, pwdata, pstrb);
        IDX_GAIN_CAL_B:   set_b.gain   <= merge(set_b.gain, pwdata, pstrb);
        default:          ;
      endcase
    end
  end

  css_set_mux u_mux (
    .sel_reg (calibration_set_select),
    .slot    (raw_result.slot),
    .set_a   (set_a),
    .set_b   (set_b),
    .chosen  (chosen),
    .apply   (apply)
  );

  css_cal_path u_path (
    .pclk       (pclk),
    .presetn    (presetn),
    .in_valid   (raw_valid),
    .in_result  (raw_result),
    .cal        (chosen),
    .apply      (apply),
    .scale_2x   (scale_2x),
    .out_valid  (cal_valid),
    .out_result (cal_result)
  );

endmodule

// ==== shared/css_pkg.sv ====
// Constants, field layouts and carrier types for the calibration set select block.
// Assumes a single 125 MHz clock and software access over APB with 32-bit data.
// Overview of operation
// - Part revision register: read-only 3-bit silicon revision in bits 2:0, rest zero.
// - Two independent calibration sets, A and B, each an offset and a gain.
// - Selector 00 applies set A to that slot's result; 00 is the reset value.
// - Selector 01 applies set B to that slot's result instead of set A.
// - Selector 10 or 11 skips system calibration; only self-calibrated data passes.
// - Selectors for slots 7, 6, 4 sit at bits 15:14, 13:12, 9:8, read-write.
// - Selectors for slots 3, 2, 1 sit at bits 7:6, 5:4, 3:2, read-write.
// - Slot 0 selector at bits 1:0; no slot 5 selector; bits 11:10, 23:16 unused.
// - Offset subtracted after self-calibration, before gain and before the scale factor.
// - Gain is unsigned fixed point, one integer bit, binary point after the MSB.
package css_pkg;

  localparam int DATA_W = 24;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PART_REVISION = 8'h11;
  localparam logic [7:0] IDX_CAL_SET_SEL   = 8'h12;
  localparam logic [7:0] IDX_OFFSET_CAL_A  = 8'h13;
  localparam logic [7:0] IDX_OFFSET_CAL_B  = 8'h14;
  localparam logic [7:0] IDX_GAIN_CAL_A    = 8'h15;
  localparam logic [7:0] IDX_GAIN_CAL_B    = 8'h16;

  // Revision field position.
  localparam int REV_LSB = 0;
  localparam int REV_W   = 3;

  // Selector fields, indexed by slot; slot 5 has none.
  localparam int SEL_W = 2;
  localparam int SLOT7_SEL_LSB = 14;
  localparam int SLOT6_SEL_LSB = 12;
  localparam int SLOT4_SEL_LSB = 8;
  localparam int SLOT3_SEL_LSB = 6;
  localparam int SLOT2_SEL_LSB = 4;
  localparam int SLOT1_SEL_LSB = 2;
  localparam int SLOT0_SEL_LSB = 0;
  localparam logic [23:0] SEL_USED_MASK = 24'h00_F3FF;

  // Reset values.
  localparam logic [23:0] SEL_RESET    = 24'h00_0000;
  localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
  localparam logic [23:0] GAIN_RESET   = 24'h80_0000;

  // Gain has 23 fraction bits.
  localparam int GAIN_FRAC = 23;

  typedef enum logic [1:0] {
    CSS_SEL_SET_A = 2'b00,
    CSS_SEL_SET_B = 2'b01,
    CSS_SEL_NONE  = 2'b10,
    CSS_SEL_NONE2 = 2'b11
  } css_sel_e;

  typedef struct packed {
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] gain;
  } css_cal_set_t;

  typedef struct packed {
    logic [2:0]        slot;
    logic [DATA_W-1:0] data;
  } css_result_t;

  // Clamps a wide signed value into the 24-bit two's complement range.
  function automatic logic [DATA_W-1:0] css_sat24(input logic signed [49:0] v);
    if (v > 50'sd8388607) begin
      return 24'h7F_FFFF;
    end else if (v < -50'sd8388608) begin
      return 24'h80_0000;
    end else begin
      return v[DATA_W-1:0];
    end
  endfunction

  // Returns the selector field of one slot; slot 5 reads as no calibration.
  function automatic css_sel_e css_slot_sel(input logic [23:0] sel_reg,
                                            input logic [2:0]  slot);
    case (slot)
      3'd7:    return css_sel_e'(sel_reg[SLOT7_SEL_LSB +: SEL_W]);
      3'd6:    return css_sel_e'(sel_reg[SLOT6_SEL_LSB +: SEL_W]);
      3'd4:    return css_sel_e'(sel_reg[SLOT4_SEL_LSB +: SEL_W]);
      3'd3:    return css_sel_e'(sel_reg[SLOT3_SEL_LSB +: SEL_W]);
      3'd2:    return css_sel_e'(sel_reg[SLOT2_SEL_LSB +: SEL_W]);
      3'd1:    return css_sel_e'(sel_reg[SLOT1_SEL_LSB +: SEL_W]);
      3'd0:    return css_sel_e'(sel_reg[SLOT0_SEL_LSB +: SEL_W]);
      default: return CSS_SEL_NONE;
    endcase
  endfunction

endpackage

// ==== src/css_set_mux.sv ====
// Chooses the calibration set for a result slot from the selector register.
// Assumes the selector register is stable while a result is in flight.
`timescale 1ns/1ns
module css_set_mux
  import css_pkg::*;
(
  input  wire logic [23:0]  sel_reg,
  input  wire logic [2:0]   slot,
  input  wire css_cal_set_t set_a,
  input  wire css_cal_set_t set_b,
  output css_cal_set_t      chosen,
  output logic              apply
);

  css_sel_e sel;

  always_comb begin
    sel    = css_slot_sel(sel_reg, slot);
    chosen = set_a;
    apply  = 1'b0;
    unique case (sel)
      CSS_SEL_SET_A: begin
        chosen = set_a;
        apply  = 1'b1;
      end
      CSS_SEL_SET_B: begin
        chosen = set_b;
        apply  = 1'b1;
      end
      CSS_SEL_NONE, CSS_SEL_NONE2: begin
        apply = 1'b0;
      end
    endcase
  end

endmodule

// ==== src/css_cal_path.sv ====
// Applies offset, gain and scale factor to one self-calibrated result.
// Assumes one result per cycle at most; output is registered one cycle later.
`timescale 1ns/1ns
module css_cal_path
  import css_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  input  wire css_result_t  in_result,
  input  wire css_cal_set_t cal,
  input  wire logic         apply,
  input  wire logic         scale_2x,
  output logic              out_valid,
  output css_result_t       out_result
);

  logic signed [49:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;
  logic [DATA_W-1:0]  after_off;
  logic [DATA_W-1:0]  after_gain;
  logic [DATA_W-1:0]  next_data;

  always_comb begin
    // Offset comes off the self-calibrated value first.
    diff      = 50'(signed'(in_result.data)) - 50'(signed'(cal.offset));
    after_off = css_sat24(diff);
    // Gain is 1.23 unsigned; the product is shifted back by the fraction bits.
    prod       = (50'(signed'(after_off)) * signed'({26'h000_0000, cal.gain})) >>> GAIN_FRAC;
    after_gain = apply ? css_sat24(prod) : in_result.data;
    // Unipolar/bipolar scale factor comes last.
    scaled    = 50'(signed'(after_gain)) <<< 1;
    next_data = scale_2x ? css_sat24(scaled) : after_gain;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_result <= '0;
    end else if (in_valid) begin
      out_result.slot <= in_result.slot;
      out_result.data <= next_data;
    end
  end

endmodule

// ==== tb/css_top_monitor.sv ====
// Checker for the register port and the result path of css_top.
// Assumes it is bound to css_top and sees its ports only.
`timescale 1ns/1ns
module css_top_monitor
  import css_pkg::*;
#(
  parameter logic [2:0] SILICON_REVISION = 3'h1
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        raw_valid,
  input wire css_result_t raw_result,
  input wire logic        scale_2x,
  input wire logic        cal_valid,
  input wire css_result_t cal_result
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rev_value: assert property (
    rd && paddr == 32'h0000_0044 |-> prdata == {29'h0000_0000, SILICON_REVISION})
    else $error("revision read wrong");
  a_sel_unused_zero: assert property (
    rd && paddr == 32'h0000_0048 |-> prdata[31:16] == 16'h0000 && prdata[11:10] == 2'b00)
    else $error("unused selector bits not zero");
  a_sel_no_error: assert property (pready && paddr == 32'h0000_0048 |-> !pslverr)
    else $error("selector access refused");
  a_cal_follows: assert property (
    raw_valid |=> cal_valid ##0 cal_result.slot == $past(raw_result.slot))
    else $error("result missing or slot changed");
  a_cal_cause: assert property (cal_valid |-> $past(raw_valid))
    else $error("result without input");
  a_slot5_plain: assert property (
    raw_valid && raw_result.slot == 3'h5 && !scale_2x
    |=> cal_result.data == $past(raw_result.data))
    else $error("slot 5 result altered");
  cover property (rd && paddr == 32'h0000_0048);
  cover property (pslverr);
  cover property (cal_valid && scale_2x);
endmodule

bind css_top css_top_monitor #(.SILICON_REVISION(SILICON_REVISION)) css_top_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .raw_valid(raw_valid), .raw_result(raw_result),
  .scale_2x(scale_2x), .cal_valid(cal_valid), .cal_result(cal_result));

// ==== tb/css_host_model.sv ====
// Host controller model: an APB master issuing one transfer per call.
// Assumes the slave answers with pready; the bench watchdog ends hangs.
`timescale 1ns/1ns
module css_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data shows a changed pattern, not the last value.
    pwdata <= ~d;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for css_top: register access and set selection per slot.
// Assumes css_host_model drives APB and the bench drives the result path.
`timescale 1ns/1ns
module testbench;
  import css_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        raw_valid, scale_2x, cal_valid;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  css_result_t raw_result, cal_result;
  int          error_cnt, num_checks;
  typedef struct {logic [23:0] sel; logic [2:0] slot; logic [23:0] exp;} css_row_t;
  // Set A: offset 16, gain 0.5; set B: offset 4, gain 1.0; raw value 1000.
  css_row_t rows[9] = '{
    '{24'h00_0000, 3'd0, 24'h00_01EC}, '{24'h00_4000, 3'd7, 24'h00_03E4},
    '{24'h00_2000, 3'd6, 24'h00_03E8}, '{24'h00_0300, 3'd4, 24'h00_03E8},
    '{24'h00_0040, 3'd3, 24'h00_03E4}, '{24'h00_0020, 3'd2, 24'h00_03E8},
    '{24'h00_0004, 3'd1, 24'h00_03E4}, '{24'h00_C000, 3'd4, 24'h00_01EC},
    '{24'hFF_FFFF, 3'd5, 24'h00_03E8}};
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  css_top css_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .raw_valid(raw_valid), .raw_result(raw_result),
    .scale_2x(scale_2x), .cal_valid(cal_valid), .cal_result(cal_result));
  css_host_model host_i (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [31:0] a, input logic [31:0] d);
    host_i.xfer(w, a, d, rd, err);
  endtask
  task automatic conv(input logic [2:0] s);
    @(posedge pclk);
    raw_valid <= 1'b1;
    raw_result <= {s, 24'h00_03E8};
    @(posedge pclk);
    raw_valid <= 1'b0;
    #1 chk(32'(cal_valid), 32'h0000_0001);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    presetn = 1'b0;
    raw_valid = 1'b0;
    raw_result = '0;
    scale_2x = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, 32'h0000_0048, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    rw(1'b1, 32'h0000_0044, 32'hFFFF_FFFF);
    rw(1'b0, 32'h0000_0044, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    rw(1'b1, 32'h0000_004C, 32'h0000_0010);
    rw(1'b1, 32'h0000_0054, 32'h0040_0000);
    rw(1'b1, 32'h0000_0050, 32'h0000_0004);
    rw(1'b0, 32'h0000_0054, 32'h0000_0000);
    chk(rd, 32'h0040_0000);
    rw(1'b0, 32'h0000_0058, 32'h0000_0000);
    chk(rd, 32'h0080_0000);
    foreach (rows[i]) begin
      rw(1'b1, 32'h0000_0048, {8'h00, rows[i].sel});
      rw(1'b0, 32'h0000_0048, 32'h0000_0000);
      chk(rd, {8'h00, rows[i].sel & SEL_USED_MASK});
      conv(rows[i].slot);
      chk({8'h00, cal_result.data}, {8'h00, rows[i].exp});
    end
    scale_2x <= 1'b1;
    rw(1'b1, 32'h0000_0048, 32'h0000_0000);
    conv(3'd0);
    chk({8'h00, cal_result.data}, 32'h0000_03D8);
    scale_2x <= 1'b0;
    rw(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    rw(1'b0, 32'h0000_0049, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    rw(1'b1, 32'h0000_0048, 32'h0000_5555);
    rw(1'b0, 32'h0000_0048, 32'h0000_0000);
    chk(rd, 32'h0000_5155);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, 32'h0000_0048, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
